// [ft_cmd_pkg.sv]
// Purpose: Constants and types for the force/torque serial command interpreter.
// Assumes: Byte-wide serial receiver and transmitter on the mclk domain.
// Notes:   Records are sent in the binary form, error byte first.
package ft_cmd_pkg;
  localparam int       FT_W          = 96;
  localparam int       BUF_DEPTH     = 8;
  localparam logic [7:0] CH_CR       = 8'h0D;
  localparam logic [7:0] CH_LF       = 8'h0A;
  localparam logic [7:0] CH_ACK      = 8'h06;
  localparam logic [7:0] CH_PROMPT   = 8'h3E;
  localparam logic [7:0] CH_CTRL_T   = 8'h14;
  localparam logic [7:0] CH_SPACE    = 8'h20;
  localparam logic [7:0] CH_ERR      = 8'h3F;
  localparam logic [15:0] NAME_ANALOG = 16'h4341;
  localparam logic [15:0] NAME_FAST   = 16'h4346;
  localparam logic [15:0] NAME_LF     = 16'h434C;
  localparam logic [15:0] NAME_VEC    = 16'h4356;
  localparam logic [15:0] NAME_REC    = 16'h5152;
  localparam logic [15:0] NAME_STREAM = 16'h5153;
  localparam logic       RST_ANALOG   = 1'b0;
  localparam logic [1:0] RST_LEVEL    = 2'h0;
  localparam logic       RST_LF       = 1'b1;
  localparam logic [5:0] CV_FACTORY   = 6'h3F;
  localparam logic [5:0] COMP_PRESENT = 6'h3F;
  localparam logic [3:0] REC_LAST     = 4'hC;
  localparam logic [3:0] OFS_SETUP      = 4'h0;
  localparam logic [3:0] OFS_IRQ_STATUS = 4'h4;
  localparam logic [3:0] OFS_IRQ_MASK   = 4'h8;
  localparam logic [3:0] OFS_STATE      = 4'hC;
  localparam int IRQ_DONE  = 0;
  localparam int IRQ_ERR   = 1;
  localparam int IRQ_STOP  = 2;
  localparam int IRQ_FAULT = 3;
  localparam int SETUP_ANALOG = 0;
  localparam int SETUP_LEVEL  = 1;
  localparam int SETUP_LF     = 3;
  localparam int SETUP_VEC    = 4;
  localparam int STATE_ERR    = 0;
  localparam int STATE_BUSY   = 2;
  localparam int STATE_STREAM = 3;

  typedef enum logic [2:0] {
    CMD_NONE, CMD_ANALOG, CMD_FAST, CMD_LF, CMD_VEC, CMD_REC, CMD_STREAM, CMD_BAD
  } cmd_t;

  typedef enum logic [3:0] {
    P_IDLE, P_ECHO, P_ECR, P_ELF, P_ACK1, P_VAL, P_VCR, P_VLF,
    P_ERR, P_ACK2, P_ACR, P_ALF, P_PROMPT, P_REC, P_RCR, P_RLF
  } phase_t;
endpackage

// [ft_serial_output_setup_query.sv]
// Purpose: Serial command interpreter for output setup and record queries.
// Assumes: rx and tx byte ports and sensor inputs are on the mclk domain.
// Notes:   Registers are reached over Avalon-MM with one wait cycle.
`timescale 1ns/1ps
`default_nettype none
module ft_serial_output_setup_query (
  input  wire logic                      mclk,
  input  wire logic                      reset,
  input  wire logic [3:0]                avs_address,
  input  wire logic                      avs_read,
  input  wire logic                      avs_write,
  input  wire logic [31:0]               avs_writedata,
  output logic      [31:0]               avs_readdata,
  output logic                           avs_waitrequest,
  input  wire logic                      rx_valid,
  input  wire logic [7:0]                rx_data,
  output logic                           tx_valid,
  output logic      [7:0]                tx_data,
  input  wire logic                      tx_ready,
  input  wire logic [ft_cmd_pkg::FT_W-1:0] ft_biased,
  input  wire logic [ft_cmd_pkg::FT_W-1:0] ft_unbiased,
  input  wire logic                      saturation,
  input  wire logic                      transducer_fault,
  output logic      [ft_cmd_pkg::FT_W-1:0] analog_data,
  output logic                           analog_valid,
  output logic                           monitor_enable,
  output logic                           sensor_averaging_enable,
  output logic                           bias_enable,
  output logic                           saturation_detect_enable,
  output logic                           irq
);
  import ft_cmd_pkg::*;

  typedef struct packed {
    phase_t            ph;
    cmd_t              cmd;
    logic              query, fast_poll, streaming, stop;
    logic [7:0][7:0]   cbuf;
    logic [3:0]        len, idx;
    logic              analog_en;
    logic [1:0]        level;
    logic              lf_en;
    logic [5:0]        vec;
    logic [7:0]        err_snap;
    logic [5:0][15:0]  snap;
    logic              tx_valid;
    logic [7:0]        tx_data;
    logic [FT_W-1:0]   analog;
    logic              analog_valid, waitreq;
    logic [31:0]       rdata;
    logic [3:0]        irq_st, irq_mask;
    logic              irq, mon_en, avg_en, bias_en, sat_en, fault_d;
  } state_t;

  state_t q;
  state_t d;

  function automatic logic [4:0] hex_in(input logic [7:0] c);
    if (c >= 8'h30 && c <= 8'h39) begin
      hex_in = {1'b1, c[3:0]};
    end else if ((c >= 8'h41 && c <= 8'h46) || (c >= 8'h61 && c <= 8'h66)) begin
      hex_in = {1'b1, 4'(c[3:0] + 4'h9)};
    end else begin
      hex_in = 5'h00;
    end
  endfunction

  function automatic logic [7:0] hex_out(input logic [3:0] n);
    hex_out = (n < 4'hA) ? {4'h3, n} : 8'(8'h37 + {4'h0, n});
  endfunction

  always_comb begin
    logic              free, emit, has_arg, arg_ok, bare, start_rec;
    logic [7:0]        ch, arg;
    logic [FT_W-1:0]   ft_sel;
    logic [1:0]        err;
    logic [4:0]        d1, d2;
    logic [15:0]       name;
    logic [2:0]        comp;
    logic [3:0]        ev, w1c;
    free      = 1'b0;
    emit      = 1'b0;
    ch        = 8'h00;
    ft_sel    = '0;
    err       = 2'h0;
    d1        = 5'h00;
    d2        = 5'h00;
    arg       = 8'h00;
    has_arg   = 1'b0;
    arg_ok    = 1'b0;
    bare      = 1'b0;
    name      = 16'h0000;
    comp      = 3'h0;
    ev        = 4'h0;
    w1c       = 4'h0;
    start_rec = 1'b0;
    d         = q;

    // Level decoding of suspended functions
    d.mon_en  = (q.level == 2'h0);
    d.avg_en  = (q.level == 2'h0);
    d.bias_en = (q.level < 2'h2);
    d.sat_en  = (q.level != 2'h3);
    ft_sel = (q.level >= 2'h2) ? ft_unbiased : ft_biased;
    err = {transducer_fault, saturation & (q.level != 2'h3)};

    if (q.analog_en) begin
      d.analog = ft_sel;
    end
    d.analog_valid = q.analog_en;

    // Command collection
    if (q.ph == P_IDLE && rx_valid) begin
      if (rx_data == CH_CTRL_T && q.len == 4'h0) begin
        d.fast_poll = 1'b1;
        start_rec   = 1'b1;
        d.ph        = P_REC;
        d.idx       = 4'h0;
      end else if (rx_data == CH_CR) begin
        name    = {q.cbuf[0], q.cbuf[1]};
        bare    = (q.len == 4'h2);
        has_arg = (q.len == 4'h4 || q.len == 4'h5) && q.cbuf[2] == CH_SPACE;
        d1      = hex_in(q.cbuf[3]);
        d2      = hex_in(q.cbuf[4]);
        arg     = (q.len == 4'h5) ? {d1[3:0], d2[3:0]} : {4'h0, d1[3:0]};
        arg_ok  = has_arg && d1[4] && (q.len == 4'h4 || d2[4]);
        d.query = bare;
        d.idx   = 4'h0;
        d.ph    = P_ECHO;
        d.cmd   = CMD_BAD;
        if (q.len == 4'h0) begin
          d.cmd = CMD_NONE;
        end else if (name == NAME_ANALOG && (bare || (arg_ok && arg < 8'h02))) begin
          d.cmd = CMD_ANALOG;
          if (!bare) begin
            d.analog_en = arg[0];
          end
        end else if (name == NAME_FAST && (bare || (arg_ok && arg < 8'h04))) begin
          d.cmd = CMD_FAST;
          if (!bare) begin
            d.level = arg[1:0];
          end
        end else if (name == NAME_LF && (bare || (arg_ok && arg < 8'h02))) begin
          d.cmd = CMD_LF;
          if (!bare) begin
            d.lf_en = arg[0];
          end
        end else if (name == NAME_VEC && (bare ||
                     (arg_ok && (arg & ~{2'h0, COMP_PRESENT}) == 8'h00))) begin
          d.cmd = CMD_VEC;
          if (!bare) begin
            d.vec = arg[5:0];
          end
        end else if (name == NAME_REC && bare) begin
          d.cmd = CMD_REC;
          d.ph  = P_ACK1;
        end else if (name == NAME_STREAM && bare) begin
          d.cmd       = CMD_STREAM;
          d.streaming = 1'b1;
          d.ph        = P_ACK1;
        end
        if (d.cmd == CMD_BAD) begin
          ev[IRQ_ERR] = 1'b1;
        end
      end else if (q.len < 4'(BUF_DEPTH)) begin
        d.cbuf[q.len[2:0]] = rx_data;
        d.len = q.len + 4'h1;
      end
    end else if (q.streaming && rx_valid) begin
      d.stop = 1'b1;
    end

    // Transmit sequencer
    free = !q.tx_valid || tx_ready;
    if (free) begin
      unique case (q.ph)
        P_IDLE: ;
        P_ECHO: begin
          if (q.idx < q.len) begin
            emit  = 1'b1;
            ch    = q.cbuf[q.idx[2:0]];
            d.idx = q.idx + 4'h1;
          end else begin
            d.ph = P_ECR;
          end
        end
        P_ECR, P_ELF: begin
          emit = 1'b1;
          ch   = (q.ph == P_ECR) ? CH_CR : CH_LF;
          if (q.ph == P_ECR && q.lf_en) begin
            d.ph = P_ELF;
          end else if (q.cmd == CMD_NONE) begin
            d.ph = P_PROMPT;
          end else if (q.cmd == CMD_BAD) begin
            d.ph = P_ERR;
          end else begin
            d.ph = P_ACK1;
          end
        end
        P_ACK1: begin
          emit  = 1'b1;
          ch    = CH_ACK;
          d.idx = 4'h0;
          if (q.cmd == CMD_REC || q.cmd == CMD_STREAM) begin
            start_rec = 1'b1;
            d.ph      = P_REC;
          end else begin
            d.ph = q.query ? P_VAL : P_ACK2;
          end
        end
        P_VAL: begin
          emit = 1'b1;
          d.ph = P_VCR;
          unique case (q.cmd)
            CMD_ANALOG: ch = hex_out({3'h0, q.analog_en});
            CMD_FAST:   ch = hex_out({2'h0, q.level});
            CMD_LF:     ch = hex_out({3'h0, q.lf_en});
            default: begin
              ch = (q.idx == 4'h0) ? hex_out({2'h0, q.vec[5:4]}) : hex_out(q.vec[3:0]);
              if (q.idx == 4'h0) begin
                d.idx = 4'h1;
                d.ph  = P_VAL;
              end
            end
          endcase
        end
        P_VCR, P_RCR, P_ACR: begin
          emit = 1'b1;
          ch   = CH_CR;
          if (q.lf_en) begin
            d.ph = (q.ph == P_VCR) ? P_VLF : (q.ph == P_RCR) ? P_RLF : P_ALF;
          end else begin
            d.ph = (q.ph == P_ACR) ? P_PROMPT : P_ACK2;
          end
        end
        P_VLF, P_RLF: begin
          emit = 1'b1;
          ch   = CH_LF;
          d.ph = P_ACK2;
        end
        P_ERR: begin
          emit = 1'b1;
          ch   = CH_ERR;
          d.ph = P_ACR;
        end
        P_ACK2: begin
          emit = 1'b1;
          ch   = CH_ACK;
          d.ph = P_ACR;
        end
        P_ALF: begin
          emit = 1'b1;
          ch   = CH_LF;
          d.ph = P_PROMPT;
        end
        P_PROMPT: begin
          emit          = 1'b1;
          ch            = CH_PROMPT;
          d.ph          = P_IDLE;
          d.len         = 4'h0;
          ev[IRQ_DONE]  = 1'b1;
        end
        P_REC: begin
          comp = 3'(4'(q.idx - 4'h1) >> 1);
          if (q.idx == 4'h0) begin
            emit = 1'b1;
            ch   = q.err_snap;
          end else if (q.vec[comp]) begin
            emit = 1'b1;
            ch   = q.idx[0] ? q.snap[comp][15:8] : q.snap[comp][7:0];
          end
          d.idx = q.idx + 4'h1;
          if (q.idx == REC_LAST) begin
            d.idx = 4'h0;
            if (q.fast_poll) begin
              d.fast_poll = 1'b0;
              d.ph        = P_IDLE;
            end else if (q.streaming) begin
              if (q.stop) begin
                d.streaming   = 1'b0;
                d.stop        = 1'b0;
                d.ph          = P_ACK2;
                ev[IRQ_STOP]  = 1'b1;
              end else begin
                start_rec = 1'b1;
              end
            end else begin
              d.ph = P_RCR;
            end
          end
        end
      endcase
    end
    if (start_rec) begin
      d.snap     = ft_sel;
      d.err_snap = {6'h00, err};
    end
    if (free) begin
      d.tx_valid = emit;
      d.tx_data  = emit ? ch : q.tx_data;
    end

    // Avalon-MM slave with one wait cycle
    d.waitreq = 1'b1;
    if ((avs_read || avs_write) && q.waitreq) begin
      d.waitreq = 1'b0;
      d.rdata   = 32'h0000_0000;
      unique case (avs_address)
        OFS_SETUP: begin
          d.rdata[SETUP_ANALOG]      = q.analog_en;
          d.rdata[SETUP_LEVEL +: 2]  = q.level;
          d.rdata[SETUP_LF]          = q.lf_en;
          d.rdata[SETUP_VEC +: 6]    = q.vec;
        end
        OFS_IRQ_STATUS: d.rdata[3:0] = q.irq_st;
        OFS_IRQ_MASK:   d.rdata[3:0] = q.irq_mask;
        OFS_STATE: begin
          d.rdata[STATE_ERR +: 2] = err;
          d.rdata[STATE_BUSY]     = (q.ph != P_IDLE);
          d.rdata[STATE_STREAM]   = q.streaming;
        end
        default: d.rdata = 32'h0000_0000;
      endcase
    end
    if (avs_write && !q.waitreq) begin
      if (avs_address == OFS_IRQ_STATUS) begin
        w1c = avs_writedata[3:0];
      end
      if (avs_address == OFS_IRQ_MASK) begin
        d.irq_mask = avs_writedata[3:0];
      end
    end
    d.fault_d        = transducer_fault;
    ev[IRQ_FAULT]    = transducer_fault && !q.fault_d;
    d.irq_st         = (q.irq_st & ~w1c) | ev;
    d.irq            = |(q.irq_st & q.irq_mask);
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      q           <= '0;
      q.analog_en <= RST_ANALOG;
      q.level     <= RST_LEVEL;
      q.lf_en     <= RST_LF;
      q.vec       <= CV_FACTORY;
      q.waitreq   <= 1'b1;
      {q.mon_en, q.avg_en, q.bias_en, q.sat_en} <= 4'hF;
    end else begin
      q <= d;
    end
  end

  assign avs_readdata             = q.rdata;
  assign avs_waitrequest          = q.waitreq;
  assign tx_valid                 = q.tx_valid;
  assign tx_data                  = q.tx_data;
  assign analog_data              = q.analog;
  assign analog_valid             = q.analog_valid;
  assign monitor_enable           = q.mon_en;
  assign sensor_averaging_enable  = q.avg_en;
  assign bias_enable              = q.bias_en;
  assign saturation_detect_enable = q.sat_en;
  assign irq                      = q.irq;
endmodule
`default_nettype wire

// [ft_serial_output_setup_query_props.sv]
// Purpose: Concurrent checks on the command interpreter ports.
// Assumes: One mclk domain, reset asynchronous and active high.
// Notes:   Bound into every instance of the interpreter.
`timescale 1ns/1ps
`default_nettype none
module ft_serial_output_setup_query_props (
  input wire logic                        mclk,
  input wire logic                        reset,
  input wire logic [3:0]                  avs_address,
  input wire logic                        avs_read,
  input wire logic                        avs_write,
  input wire logic [31:0]                 avs_readdata,
  input wire logic                        avs_waitrequest,
  input wire logic                        tx_valid,
  input wire logic [7:0]                  tx_data,
  input wire logic                        tx_ready,
  input wire logic [ft_cmd_pkg::FT_W-1:0] ft_biased,
  input wire logic [ft_cmd_pkg::FT_W-1:0] ft_unbiased,
  input wire logic [ft_cmd_pkg::FT_W-1:0] analog_data,
  input wire logic                        analog_valid,
  input wire logic                        monitor_enable,
  input wire logic                        sensor_averaging_enable,
  input wire logic                        bias_enable,
  input wire logic                        saturation_detect_enable
);
  import ft_cmd_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  sequence bus_req_s;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence bus_ans_s;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  sequence tx_stall_s;
    tx_valid && !tx_ready;
  endsequence
  bus_answer_a: assert property (bus_req_s |=> bus_ans_s)
    else $error("bus answer not exactly one cycle");
  unmapped_zero_a: assert property (avs_read && avs_waitrequest && avs_address[1:0] != 2'h0
    |=> avs_readdata == 32'h0) else $error("unmapped read not zero");
  tx_hold_a: assert property (tx_stall_s |=> tx_valid && $stable(tx_data))
    else $error("tx byte dropped while stalled");
  analog_freeze_a: assert property (!analog_valid |-> $stable(analog_data))
    else $error("analog data moved while disabled");
  analog_copy_a: assert property (analog_valid && $past(analog_valid) && $stable(bias_enable)
    |-> analog_data == ($past(bias_enable) ? $past(ft_biased) : $past(ft_unbiased)))
    else $error("analog data not current");
  level_order_a: assert property (!bias_enable |-> !monitor_enable && !sensor_averaging_enable)
    else $error("level two without level one");
  sat_order_a: assert property (!saturation_detect_enable |-> !bias_enable)
    else $error("level three without level two");
  avg_pair_a: assert property (monitor_enable == sensor_averaging_enable)
    else $error("monitor and averaging differ");
endmodule
bind ft_serial_output_setup_query ft_serial_output_setup_query_props
  ft_serial_output_setup_query_props_i (.mclk(mclk), .reset(reset), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .tx_valid(tx_valid), .tx_data(tx_data),
  .tx_ready(tx_ready), .ft_biased(ft_biased), .ft_unbiased(ft_unbiased),
  .analog_data(analog_data), .analog_valid(analog_valid), .monitor_enable(monitor_enable),
  .sensor_averaging_enable(sensor_averaging_enable), .bias_enable(bias_enable),
  .saturation_detect_enable(saturation_detect_enable));
`default_nettype wire

// [ft_host_model.sv]
// Purpose: Host computer on the serial command line.
// Assumes: Byte-wide link in the mclk domain.
// Notes:   Ready stalls every other pair of cycles when asked.
`timescale 1ns/1ps
`default_nettype none
module ft_host_model (
  input  wire logic       mclk,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            tx_ready,
  output logic            rx_valid,
  output logic [7:0]      rx_data
);
  logic [7:0] got_q[$];
  logic       stall;
  int         n;
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_ready = 1'b1;
    stall = 1'b0;
    n = 0;
  end
  always @(posedge mclk) begin
    n <= n + 1;
    if (tx_valid && tx_ready) got_q.push_back(tx_data);
    tx_ready <= !(stall && n[1]);
  end
  // One byte per pulse; line shows junk afterwards
  task automatic send(input logic [7:0] b);
    @(posedge mclk);
    rx_valid <= 1'b1;
    rx_data <= b;
    @(posedge mclk);
    rx_valid <= 1'b0;
    rx_data <= ~b;
  endtask
endmodule
`default_nettype wire

// [tb_ft_serial_output_setup_query.sv]
// Purpose: Self-checking bench for the serial command interpreter.
// Assumes: Host model sinks tx and sources rx bytes.
// Notes:   Records are checked in the binary form only.
`timescale 1ns/1ps
`default_nettype none
module tb_ft_serial_output_setup_query;
  import ft_cmd_pkg::*;
  logic            mclk, reset, avs_read, avs_write, avs_waitrequest, irq, lf;
  logic [3:0]      avs_address;
  logic [31:0]     avs_writedata, avs_readdata;
  logic            rx_valid, tx_valid, tx_ready, saturation, transducer_fault;
  logic [7:0]      rx_data, tx_data;
  logic [FT_W-1:0] ft_b, ft_u, analog_data;
  logic            analog_valid, monitor_enable, sensor_averaging_enable;
  logic            bias_enable, saturation_detect_enable;
  logic [7:0]      exp[$];
  int              fails, check_count;
  localparam logic [31:0] SETUP_RST = {22'h0, CV_FACTORY, 4'h8};
  ft_serial_output_setup_query ft_serial_output_setup_query_i (
    .mclk(mclk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .rx_valid(rx_valid), .rx_data(rx_data),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .ft_biased(ft_b),
    .ft_unbiased(ft_u), .saturation(saturation), .transducer_fault(transducer_fault),
    .analog_data(analog_data), .analog_valid(analog_valid), .monitor_enable(monitor_enable),
    .sensor_averaging_enable(sensor_averaging_enable), .bias_enable(bias_enable),
    .saturation_detect_enable(saturation_detect_enable), .irq(irq));
  ft_host_model ft_host_model_i (.mclk(mclk), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data));
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  task automatic chk(input string what, input logic [95:0] e, input logic [95:0] g);
    check_count++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", what, e, g);
      fails++;
    end
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge mclk);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= d;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input string what);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(what, e, q);
  endtask
  task automatic cmd(input string s);
    for (int i = 0; i < s.len(); i++) ft_host_model_i.send(s[i]);
    ft_host_model_i.send(CH_CR);
  endtask
  task automatic echo(input string s);
    for (int i = 0; i < s.len(); i++) exp.push_back(s[i]);
  endtask
  task automatic crlf();
    exp.push_back(CH_CR);
    if (lf) exp.push_back(CH_LF);
  endtask
  task automatic rec(input logic [1:0] e, input logic [5:0] v, input logic [95:0] d);
    exp.push_back({6'h0, e});
    for (int i = 0; i < 6; i++) if (v[i]) exp = {exp, d[16*i+8 +: 8], d[16*i +: 8]};
  endtask
  task automatic wait_n(input int n);
    for (int k = 0; k < 3000 && ft_host_model_i.got_q.size() < n; k++) @(posedge mclk);
  endtask
  task automatic flush();
    repeat (200) @(posedge mclk);
    ft_host_model_i.got_q.delete();
  endtask
  task automatic reply(input string what);
    wait_n(exp.size());
    repeat (30) @(posedge mclk);
    chk({what, " length"}, exp.size(), ft_host_model_i.got_q.size());
    foreach (exp[i]) if (i < ft_host_model_i.got_q.size()) chk(what, exp[i], ft_host_model_i.got_q[i]);
    exp.delete();
    ft_host_model_i.got_q.delete();
  endtask
  task automatic setup(input string s);
    cmd(s);
    echo(s);
    crlf();
    exp = {exp, CH_ACK, CH_ACK};
    crlf();
    exp.push_back(CH_PROMPT);
    reply(s);
  endtask
  task automatic bare(input string s, input string v);
    cmd(s);
    echo(s);
    crlf();
    exp.push_back(CH_ACK);
    echo(v);
    crlf();
    exp.push_back(CH_ACK);
    crlf();
    exp.push_back(CH_PROMPT);
    reply(s);
  endtask
  task automatic poll(input logic [1:0] e, input logic [95:0] d);
    repeat (3) @(posedge mclk);
    ft_host_model_i.send(CH_CTRL_T);
    rec(e, 6'h3F, d);
    reply("record");
  endtask
  task automatic t_defaults();
    logic [31:0] q;
    chk("analog_valid", 1'b0, analog_valid);
    chk("enables", 4'hF, {monitor_enable, sensor_averaging_enable, bias_enable,
        saturation_detect_enable});
    bus(1'b1, OFS_SETUP, 32'h0, q);
    rd(OFS_SETUP, SETUP_RST, "setup reset");
    rd(4'h2, 32'h0, "unmapped");
  endtask
  task automatic t_analog();
    logic [FT_W-1:0] old;
    setup("CA 1");
    chk("analog_valid", 1'b1, analog_valid);
    chk("analog_data", ft_b, analog_data);
    bare("CA", "1");
    rd(OFS_SETUP, SETUP_RST | 32'h1, "analog kept");
    setup("CA 0");
    old = analog_data;
    ft_b <= ~ft_b;
    repeat (5) @(posedge mclk);
    chk("analog frozen", old, analog_data);
    ft_b <= ~ft_b;
  endtask
  task automatic t_fast();
    logic [95:0] d;
    for (int l = 0; l < 4; l++) begin
      setup($sformatf("CF %0d", l));
      chk("enables", {l == 0, l == 0, l < 2, l != 3}, {monitor_enable,
          sensor_averaging_enable, bias_enable, saturation_detect_enable});
      d = (l < 2) ? ft_b : ft_u;
      saturation <= 1'b1;
      transducer_fault <= 1'b0;
      poll((l == 3) ? 2'h0 : 2'h1, d);
      transducer_fault <= 1'b1;
      poll((l == 3) ? 2'h2 : 2'h3, d);
      rd(OFS_STATE, (l == 3) ? 32'h2 : 32'h3, "state");
    end
    saturation <= 1'b0;
    transducer_fault <= 1'b0;
    setup("CF 0");
    chk("enables back", 4'hF, {monitor_enable, sensor_averaging_enable, bias_enable,
        saturation_detect_enable});
  endtask
  task automatic t_linefeed();
    cmd("CL 0");
    flush();
    lf = 1'b0;
    bare("CL", "0");
    cmd("CL 1");
    flush();
    lf = 1'b1;
    bare("CL", "1");
  endtask
  task automatic t_vector();
    setup("CV 14");
    cmd("QR");
    exp.push_back(CH_ACK);
    rec(2'h0, 6'h14, ft_b);
    crlf();
    exp.push_back(CH_ACK);
    crlf();
    exp.push_back(CH_PROMPT);
    reply("QR");
    bare("CV", "14");
    reset <= 1'b1;
    @(posedge mclk);
    reset <= 1'b0;
    rd(OFS_SETUP, SETUP_RST, "setup after reset");
  endtask
  task automatic t_error();
    logic [31:0] q;
    bus(1'b1, OFS_IRQ_MASK, 32'h2, q);
    cmd("CV 7F");
    echo("CV 7F");
    crlf();
    exp.push_back(CH_ERR);
    crlf();
    exp.push_back(CH_PROMPT);
    reply("bad vector");
    chk("irq set", 1'b1, irq);
    bus(1'b0, OFS_IRQ_STATUS, 32'h0, q);
    chk("status error", 1'b1, q[IRQ_ERR]);
    bus(1'b1, OFS_IRQ_STATUS, 32'hF, q);
    bus(1'b1, OFS_IRQ_MASK, 32'h0, q);
    cmd("CV 7F");
    flush();
    chk("irq masked", 1'b0, irq);
    rd(OFS_SETUP, SETUP_RST, "vector kept");
  endtask
  task automatic t_stream();
    int n;
    logic [31:0] q;
    ft_host_model_i.stall <= 1'b1;
    cmd("QS");
    wait_n(27);
    ft_host_model_i.send(CH_CR);
    for (int k = 0; k < 3000 && !(ft_host_model_i.got_q.size() > 0 &&
         ft_host_model_i.got_q[$] == CH_PROMPT); k++) @(posedge mclk);
    n = ft_host_model_i.got_q.size();
    chk("stream ack", CH_ACK, ft_host_model_i.got_q[0]);
    chk("stream whole", 0, (n - 5) % 13);
    chk("stream first", {8'h00, ft_b[15:8]}, {ft_host_model_i.got_q[1],
        ft_host_model_i.got_q[2]});
    chk("stream tail", {CH_ACK, CH_CR, CH_LF, CH_PROMPT}, {ft_host_model_i.got_q[n-4],
        ft_host_model_i.got_q[n-3], ft_host_model_i.got_q[n-2], ft_host_model_i.got_q[n-1]});
    bus(1'b0, OFS_IRQ_STATUS, 32'h0, q);
    chk("stream ended", 1'b1, q[IRQ_STOP]);
    ft_host_model_i.stall <= 1'b0;
    flush();
  endtask
  initial begin
    repeat (40000) @(posedge mclk);
    fails++;
    close_out();
  end
  initial begin
    fails = 0;
    check_count = 0;
    lf = 1'b1;
    reset = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    saturation = 1'b0;
    transducer_fault = 1'b0;
    ft_b = {16'hA6B6, 16'hA5B5, 16'hA4B4, 16'hA3B3, 16'hA2B2, 16'hA1B1};
    ft_u = {16'hC6D6, 16'hC5D5, 16'hC4D4, 16'hC3D3, 16'hC2D2, 16'hC1D1};
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    t_defaults();
    t_analog();
    t_fast();
    t_linefeed();
    t_vector();
    t_error();
    t_stream();
    close_out();
  end
endmodule
`default_nettype wire
